// ---- common/flow_decode_pkg.sv ----
package flow_decode_pkg;
  localparam int DW = 24;
  localparam int BUS_DW = 32;
  localparam int ADR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_OPWORD = 8'h00;
  localparam logic [7:0] OFS_EXTWORD = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_OPERAND = 8'h0c;
  localparam logic [7:0] OFS_COND = 8'h10;
  localparam logic [7:0] OFS_LOOP_END = 8'h14;
  localparam logic [7:0] OFS_LOOP_CNT = 8'h18;
  localparam logic [7:0] OFS_SR = 8'h1c;
  localparam logic [7:0] OFS_SP = 8'h20;
  localparam logic [7:0] OFS_STK_HI = 8'h24;
  localparam logic [7:0] OFS_STK_LO = 8'h28;
  localparam logic [7:0] OFS_RESULT = 8'h2c;
  localparam logic [7:0] OFS_OPADDR = 8'h30;
  localparam logic [2:0] AREG_PAGE = 3'h2;
  // Opcode patterns
  localparam logic [23:0] JUMP_LONG_CODE = 24'h0d10c0;
  localparam logic [23:0] JUMP_REG_MASK = 24'hfff8ff;
  localparam logic [23:0] JUMP_REG_CODE = 24'h0d18c0;
  localparam logic [23:0] JUMP_SHORT_MASK = 24'hfffc20;
  localparam logic [23:0] JUMP_SHORT_CODE = 24'h050c00;
  localparam logic [23:0] CLR_MASK = 24'hffc0a0;
  localparam logic [23:0] CLR_REG_MASK = 24'hffc0e0;
  localparam logic [23:0] CLR_EA_CODE = 24'h0c8000;
  localparam logic [23:0] CLR_AA_CODE = 24'h0c8080;
  localparam logic [23:0] CLR_PP_CODE = 24'h0cc000;
  localparam logic [23:0] CLR_QQ_CODE = 24'h048000;
  localparam logic [23:0] CLR_REG_CODE = 24'h0cc080;
  localparam logic [23:0] IO_P_BASE = 24'hffffc0;
  localparam logic [23:0] IO_Q_BASE = 24'hffff80;
  localparam logic [23:0] PC_STEP = 24'h000001;
  localparam logic [4:0] BIT_LIMIT = 5'h18;
  localparam logic [5:0] STK_HI_REG_CODE = 6'h3c;
  // Status word bits
  localparam int SR_LOOP = 15;
  localparam int SR_FOREVER = 12;
  localparam int SR_S = 7;
  // Result register bits
  localparam int RES_TAKEN = 0;
  localparam int RES_ILLEGAL = 1;
  localparam int RES_EA_UPD = 2;
  localparam int RES_SPACE = 3;
  localparam int RES_EA_LSB = 4;
endpackage

// ---- src/flow_decode.sv ----
// Local design decisions: the placing of the registers and register access over Avalon-MM.
module flow_decode #(
  parameter int SP_W = 4,
  parameter logic [23:0] LOOP_EXIT_MASK = 24'hfffff0,
  parameter logic [23:0] LOOP_EXIT_CODE = 24'h000210
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [flow_decode_pkg::ADR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [flow_decode_pkg::BUS_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [flow_decode_pkg::BUS_DW-1:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int DW = flow_decode_pkg::DW;
  localparam int DEPTH = 1 << SP_W;

  generate
    if (SP_W < 2 || SP_W > 6) begin : g_bad
      $error("SP_W must lie in 2..6");
    end
  endgenerate

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    EXEC = 3'b010,
    POP = 3'b100
  } state_t;

  logic rst_meta, rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  state_t state;
  logic [DW-1:0] op, ext, pc, operand, loop_end, loop_cnt, sr, op_addr;
  logic [DW-1:0] areg [8];
  logic [DW-1:0] stk_hi [DEPTH];
  logic [DW-1:0] stk_lo [DEPTH];
  logic [SP_W-1:0] sp;
  logic cond;
  logic [9:0] result;
  logic [DW-1:0] rd_word;
  logic [flow_decode_pkg::BUS_DW-1:0] rd_data;

  // Bus handshake: one wait cycle in IDLE, more while EXEC or POP, then a single low cycle of acceptance
  logic req, accept, do_write;
  logic [DW-1:0] wmask, wval;
  assign req = avs_read || avs_write;
  assign accept = req && avs_waitrequest && state == IDLE;
  assign do_write = avs_write && !avs_waitrequest;
  assign wmask = {{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                  {8{avs_byteenable[0]}}};
  assign wval = avs_writedata[DW-1:0] & wmask;

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
      input logic [DW-1:0] m, input logic [DW-1:0] v);
    merge = (old & ~m) | v;
  endfunction

  logic hit_op, hit_ext, hit_pc, hit_opnd, hit_cond, hit_lend, hit_lcnt;
  logic hit_sr, hit_sp, hit_shi, hit_slo, hit_areg;
  assign hit_op = do_write && avs_address == flow_decode_pkg::OFS_OPWORD;
  assign hit_ext = do_write && avs_address == flow_decode_pkg::OFS_EXTWORD;
  assign hit_pc = do_write && avs_address == flow_decode_pkg::OFS_PC;
  assign hit_opnd = do_write && avs_address == flow_decode_pkg::OFS_OPERAND;
  assign hit_cond = do_write && avs_address == flow_decode_pkg::OFS_COND;
  assign hit_lend = do_write && avs_address == flow_decode_pkg::OFS_LOOP_END;
  assign hit_lcnt = do_write && avs_address == flow_decode_pkg::OFS_LOOP_CNT;
  assign hit_sr = do_write && avs_address == flow_decode_pkg::OFS_SR;
  assign hit_sp = do_write && avs_address == flow_decode_pkg::OFS_SP;
  assign hit_shi = do_write && avs_address == flow_decode_pkg::OFS_STK_HI;
  assign hit_slo = do_write && avs_address == flow_decode_pkg::OFS_STK_LO;
  assign hit_areg = do_write && avs_address[7:5] == flow_decode_pkg::AREG_PAGE;

  // Decode of the first word
  logic in_exec, is_jump_long, is_jump_reg, is_jump_short, is_exit;
  logic is_ea, is_aa, is_pp, is_qq, is_reg, is_clr, bit_ok, legal;
  assign in_exec = state == EXEC;
  assign is_jump_long = op == flow_decode_pkg::JUMP_LONG_CODE;
  assign is_jump_reg = (op & flow_decode_pkg::JUMP_REG_MASK)
                       == flow_decode_pkg::JUMP_REG_CODE;
  assign is_jump_short = (op & flow_decode_pkg::JUMP_SHORT_MASK)
                         == flow_decode_pkg::JUMP_SHORT_CODE;
  assign is_ea = (op & flow_decode_pkg::CLR_MASK)
                 == flow_decode_pkg::CLR_EA_CODE;
  assign is_aa = (op & flow_decode_pkg::CLR_MASK)
                 == flow_decode_pkg::CLR_AA_CODE;
  assign is_pp = (op & flow_decode_pkg::CLR_MASK)
                 == flow_decode_pkg::CLR_PP_CODE;
  assign is_qq = (op & flow_decode_pkg::CLR_MASK)
                 == flow_decode_pkg::CLR_QQ_CODE;
  assign is_reg = (op & flow_decode_pkg::CLR_REG_MASK)
                  == flow_decode_pkg::CLR_REG_CODE;
  assign is_clr = is_ea || is_aa || is_pp || is_qq || is_reg;
  // Unknown opcode space, so the exit pattern is a parameter
  assign is_exit = (op & LOOP_EXIT_MASK) == LOOP_EXIT_CODE;
  assign bit_ok = op[4:0] < flow_decode_pkg::BIT_LIMIT;
  assign legal = is_jump_long || is_jump_reg || is_jump_short
                 || (is_clr && bit_ok) || is_exit;

  // Bit-test source and operand address
  logic stk_hi_src, test_bit, clr_go;
  logic [DW-1:0] src_val, next_addr, short_disp, inc_pc, next_pc;
  assign stk_hi_src = is_reg && op[13:8] == flow_decode_pkg::STK_HI_REG_CODE;
  assign src_val = stk_hi_src ? stk_hi[sp] : operand;
  assign test_bit = src_val[op[4:0]];
  assign clr_go = is_clr && bit_ok;
  assign next_addr = is_pp ? flow_decode_pkg::IO_P_BASE + DW'(op[13:8])
                   : is_qq ? flow_decode_pkg::IO_Q_BASE + DW'(op[13:8])
                   : DW'(op[13:8]);
  assign short_disp = {{15{op[9]}}, op[9:6], op[4:0]};
  assign inc_pc = pc + flow_decode_pkg::PC_STEP;

  always_comb begin
    next_pc = pc;
    if (is_jump_long)
      next_pc = pc + ext;
    else if (is_jump_reg)
      next_pc = pc + areg[op[10:8]];
    else if (is_jump_short)
      next_pc = pc + short_disp;
    else if (clr_go)
      next_pc = test_bit ? inc_pc : pc + ext;
    else if (is_exit)
      next_pc = cond ? loop_end + flow_decode_pkg::PC_STEP
                     : inc_pc;
  end

  state_t next_state;
  assign next_state = hit_op ? EXEC
                    : (in_exec && is_exit && cond) ? POP
                    : IDLE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      state <= IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= !accept;
      if (accept)
        avs_readdata <= rd_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op <= '0;
      ext <= '0;
      operand <= '0;
      cond <= 1'b0;
    end else begin
      if (hit_op)
        op <= merge(op, wmask, wval);
      if (hit_ext)
        ext <= merge(ext, wmask, wval);
      if (hit_opnd)
        operand <= merge(operand, wmask, wval);
      if (hit_cond && avs_byteenable[0])
        cond <= avs_writedata[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pc <= '0;
    else if (hit_pc)
      pc <= merge(pc, wmask, wval);
    else if (in_exec && legal)
      pc <= next_pc;
  end

  // The exit overwrites the count: software must read it first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_end <= '0;
      loop_cnt <= '0;
    end else if (state == POP) begin
      loop_end <= stk_hi[sp];
      loop_cnt <= stk_lo[sp];
    end else begin
      if (hit_lend)
        loop_end <= merge(loop_end, wmask, wval);
      if (hit_lcnt)
        loop_cnt <= merge(loop_cnt, wmask, wval);
    end
  end

  // Only the loop flags come back; the rest of the stacked word is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sr <= '0;
    else if (hit_sr)
      sr <= merge(sr, wmask, wval);
    else if (in_exec && is_exit && cond) begin
      sr[flow_decode_pkg::SR_LOOP] <=
          stk_lo[sp][flow_decode_pkg::SR_LOOP];
      sr[flow_decode_pkg::SR_FOREVER] <=
          stk_lo[sp][flow_decode_pkg::SR_FOREVER];
    end else if (in_exec && clr_go && !is_exit)
      sr[flow_decode_pkg::SR_S] <= sr[flow_decode_pkg::SR_S]
                                   | (src_val[23] ^ src_val[22]);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sp <= '0;
    else if (hit_sp)
      sp <= avs_writedata[SP_W-1:0];
    else if ((in_exec && ((is_exit && cond) || (clr_go && stk_hi_src)))
             || state == POP)
      sp <= sp - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
      op_addr <= '0;
    end else if (in_exec) begin
      result[flow_decode_pkg::RES_TAKEN] <= clr_go ? !test_bit
          : is_exit ? cond : legal;
      result[flow_decode_pkg::RES_ILLEGAL] <= !legal;
      result[flow_decode_pkg::RES_EA_UPD] <= clr_go && is_ea;
      result[flow_decode_pkg::RES_SPACE] <= op[6];
      result[9:flow_decode_pkg::RES_EA_LSB] <= op[13:8];
      op_addr <= next_addr;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_areg
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          areg[gi] <= '0;
        else if (hit_areg && avs_address[4:2] == 3'(gi))
          areg[gi] <= merge(areg[gi], wmask, wval);
      end
    end
    for (gi = 0; gi < DEPTH; gi++) begin : g_stack
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stk_hi[gi] <= '0;
          stk_lo[gi] <= '0;
        end else if (sp == SP_W'(gi)) begin
          if (hit_shi)
            stk_hi[gi] <= merge(stk_hi[gi], wmask, wval);
          if (hit_slo)
            stk_lo[gi] <= merge(stk_lo[gi], wmask, wval);
        end
      end
    end
  endgenerate

  always_comb begin
    rd_word = '0;
    if (avs_address[7:5] == flow_decode_pkg::AREG_PAGE)
      rd_word = areg[avs_address[4:2]];
    else begin
      unique case (avs_address)
        flow_decode_pkg::OFS_OPWORD: rd_word = op;
        flow_decode_pkg::OFS_EXTWORD: rd_word = ext;
        flow_decode_pkg::OFS_PC: rd_word = pc;
        flow_decode_pkg::OFS_OPERAND: rd_word = operand;
        flow_decode_pkg::OFS_COND: rd_word = DW'(cond);
        flow_decode_pkg::OFS_LOOP_END: rd_word = loop_end;
        flow_decode_pkg::OFS_LOOP_CNT: rd_word = loop_cnt;
        flow_decode_pkg::OFS_SR: rd_word = sr;
        flow_decode_pkg::OFS_SP: rd_word = DW'(sp);
        flow_decode_pkg::OFS_STK_HI: rd_word = stk_hi[sp];
        flow_decode_pkg::OFS_STK_LO: rd_word = stk_lo[sp];
        flow_decode_pkg::OFS_RESULT: rd_word = DW'(result);
        flow_decode_pkg::OFS_OPADDR: rd_word = op_addr;
        default: rd_word = '0;
      endcase
    end
    rd_data = {8'h00, rd_word};
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  jump_long_a: assert property (in_exec && is_jump_long |=>
      pc == $past(pc) + $past(ext)) else $error("long branch target");
  jump_short_a: assert property (in_exec && is_jump_short |=>
      pc == $past(pc) + $past(short_disp)) else $error("short branch");
  jump_reg_a: assert property (in_exec && is_jump_reg |=>
      pc == $past(pc) + $past(areg[op[10:8]])) else $error("reg branch");
  clr_taken_a: assert property (in_exec && clr_go && !test_bit
      |=> pc == $past(pc) + $past(ext) && result[0])
      else $error("bit clear branch not taken");
  clr_fall_a: assert property (in_exec && clr_go && test_bit
      |=> pc == $past(pc) + 24'h000001) else $error("bit set fallthrough");
  ea_upd_a: assert property (in_exec && clr_go && is_ea
      |=> result[2]) else $error("address update missing");
  io_addr_a: assert property (in_exec && is_pp |=>
      op_addr == 24'hffffc0 + 24'($past(op[13:8]))) else $error("io map");
  stk_pop_a: assert property (in_exec && clr_go && stk_hi_src
      && !hit_sp |=> sp == $past(sp) - 1'b1)
      else $error("stack pop on read");
  exit_seq_a: assert property (in_exec && is_exit && cond
      |=> state == POP ##1 state == IDLE && sp == $past(sp, 2) - 2'd2)
      else $error("loop exit sequence");
  exit_ccr_a: assert property (in_exec && is_exit |=>
      sr[7:0] == $past(sr[7:0])) else $error("exit touched flags");
  exit_restore_a: assert property (state == POP |=>
      loop_end == $past(stk_hi[sp]) && loop_cnt == $past(stk_lo[sp]))
      else $error("loop restore");
  bus_ack_a: assert property (req && avs_waitrequest && state == IDLE
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus ack");

  taken_c: cover property (in_exec && clr_go && !test_bit);
  fall_c: cover property (in_exec && clr_go && test_bit);
  exit_c: cover property (state == POP);
  short_c: cover property (in_exec && is_jump_short && op[9]);
endmodule

// ---- verification/bit_branch_loop_exit_decode_tb.sv ----
module bit_branch_loop_exit_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] EXIT_OP = 24'h000210;
  logic clk;
  logic resetn;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rd;
  int bad_count;
  int check_count;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  flow_decode #(.SP_W(4), .LOOP_EXIT_CODE(EXIT_OP)) u_flow_decode (
    .clk(clk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  task automatic end_sim;
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait so a stuck slave cannot hang the run
  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (avs_waitrequest !== 1'b0)
      check("waitrequest", 32'h0, {31'h0, avs_waitrequest});
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {8'h00, d};
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic read_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
    bus_read(a, rd);
    check(what, exp, rd);
  endtask

  task automatic run(input logic [23:0] op, input logic [23:0] ext,
                     input logic [23:0] start);
    bus_write(flow_decode_pkg::OFS_PC, start);
    bus_write(flow_decode_pkg::OFS_EXTWORD, ext);
    bus_write(flow_decode_pkg::OFS_OPWORD, op);
  endtask

  // Bit test from 0x100 with displacement 0x40; result word left in rd
  task automatic bit_test(input logic [23:0] op, input logic [23:0] src,
                          input logic taken);
    bus_write(flow_decode_pkg::OFS_OPERAND, src);
    run(op, 24'h000040, 24'h000100);
    read_chk("program_counter", flow_decode_pkg::OFS_PC,
             taken ? 32'h140 : 32'h101);
    bus_read(flow_decode_pkg::OFS_RESULT, rd);
    check("taken", {31'h0, taken}, {31'h0, rd[0]});
  endtask

  initial begin
    resetn = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    bad_count = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    read_chk("program_counter", flow_decode_pkg::OFS_PC, 32'h0);
    run(flow_decode_pkg::JUMP_LONG_CODE, 24'hfffff0, 24'h000100);
    read_chk("long", flow_decode_pkg::OFS_PC, 32'h0000f0);
    run(24'h050fde, 24'h0, 24'h000100);
    read_chk("short neg", flow_decode_pkg::OFS_PC, 32'h0000fe);
    run(24'h050ddf, 24'h0, 24'h000100);
    read_chk("short pos", flow_decode_pkg::OFS_PC, 32'h0001ff);
    bus_write(8'h4c, 24'h000020);
    run(24'h0d1bc0, 24'h0, 24'h000100);
    read_chk("areg 3", flow_decode_pkg::OFS_PC, 32'h000120);
    bus_write(8'h5c, 24'hfffff0);
    run(24'h0d1fc0, 24'h0, 24'h000100);
    read_chk("areg 7", flow_decode_pkg::OFS_PC, 32'h0000f0);
    bit_test(24'h0cd097, 24'h7fffff, 1'b1);
    read_chk("scaling flag", flow_decode_pkg::OFS_SR, 32'h80);
    bit_test(24'h0cd097, 24'h800000, 1'b0);
    bit_test(24'h0cd080, 24'hfffffe, 1'b1);
    check("reg field", 32'h10, {26'h0, rd[9:4]});
    // Bit 24 is out of range: counter must not move
    bus_write(flow_decode_pkg::OFS_OPERAND, 24'h0);
    run(24'h0cd098, 24'h000040, 24'h000100);
    read_chk("bit 24", flow_decode_pkg::OFS_PC, 32'h000100);
    bus_read(flow_decode_pkg::OFS_RESULT, rd);
    check("illegal", 32'h1, {31'h0, rd[1]});
    // Bit-set encoding is not a bit-clear word
    run(24'h0cd0a0, 24'h000040, 24'h000100);
    read_chk("bit5 set", flow_decode_pkg::OFS_PC, 32'h000100);
    bit_test(24'h0caac3, 24'h000008, 1'b0);
    check("space y", 32'h1, {31'h0, rd[3]});
    read_chk("abs addr", flow_decode_pkg::OFS_OPADDR, 32'h2a);
    bit_test(24'h0cd505, 24'h0, 1'b1);
    check("space x", 32'h0, {31'h0, rd[3]});
    read_chk("io p", flow_decode_pkg::OFS_OPADDR, 32'hffffd5);
    bit_test(24'h049545, 24'h0, 1'b1);
    read_chk("io q", flow_decode_pkg::OFS_OPADDR, 32'hffff95);
    bit_test(24'h0c9a00, 24'h0, 1'b1);
    check("ea upd taken", 32'h1, {31'h0, rd[2]});
    bit_test(24'h0c9a00, 24'h000001, 1'b0);
    check("ea upd not", 32'h1, {31'h0, rd[2]});
    bus_write(flow_decode_pkg::OFS_SP, 24'h000005);
    bit_test(24'h0cfc80, 24'h0, 1'b1);
    read_chk("stack_pointer", flow_decode_pkg::OFS_SP, 32'h4);
    // Two stacked frames: saved loop state, then saved flags
    bus_write(flow_decode_pkg::OFS_SP, 24'h000001);
    bus_write(flow_decode_pkg::OFS_STK_HI, 24'h000111);
    bus_write(flow_decode_pkg::OFS_STK_LO, 24'h000007);
    bus_write(flow_decode_pkg::OFS_SP, 24'h000002);
    bus_write(flow_decode_pkg::OFS_STK_HI, 24'h0000aa);
    bus_write(flow_decode_pkg::OFS_STK_LO, 24'h001000);
    bus_write(flow_decode_pkg::OFS_SR, 24'h00808f);
    bus_write(flow_decode_pkg::OFS_LOOP_END, 24'h000200);
    bus_write(flow_decode_pkg::OFS_LOOP_CNT, 24'h000005);
    bus_write(flow_decode_pkg::OFS_COND, 24'h000001);
    read_chk("count first", flow_decode_pkg::OFS_LOOP_CNT, 32'h5);
    run(EXIT_OP, 24'h0, 24'h000150);
    read_chk("exit target", flow_decode_pkg::OFS_PC, 32'h201);
    read_chk("status_word", flow_decode_pkg::OFS_SR, 32'h108f);
    read_chk("loop_end_addr", flow_decode_pkg::OFS_LOOP_END, 32'h111);
    read_chk("loop_count", flow_decode_pkg::OFS_LOOP_CNT, 32'h7);
    read_chk("stack_pointer", flow_decode_pkg::OFS_SP, 32'h0);
    bus_write(flow_decode_pkg::OFS_COND, 24'h000000);
    bus_write(flow_decode_pkg::OFS_LOOP_END, 24'h000300);
    run(EXIT_OP, 24'h0, 24'h000150);
    read_chk("no exit", flow_decode_pkg::OFS_PC, 32'h151);
    read_chk("end kept", flow_decode_pkg::OFS_LOOP_END, 32'h300);
    read_chk("flags kept", flow_decode_pkg::OFS_SR, 32'h108f);
    // Unmapped offset: write dropped, read returns zero
    bus_write(8'h3c, 24'h123456);
    read_chk("unmapped", 8'h3c, 32'h0);
    end_sim();
  end

  initial begin
    #100us;
    bad_count++;
    end_sim();
  end
endmodule
